// ---- inc/rsor_pkg.sv ----
// Constants and types of the radio status and transmit observation registers
// What this block does
// R1: The status byte is shifted out on the serial data output while the command byte shifts in.
// R2: Status bit 6 sets when a payload enters the receive FIFO and clears only on a written one.
// R3: Status bit 5 sets on packet sent, or only on acknowledge when auto acknowledge is on; one clears it.
// R4: Status bit 4 sets when retransmissions run out and clears when the host writes a one.
// R5: While bit 4 is set the device stops communicating until the host clears it.
// R6: Status bits 3:1 give the pipe of the receive FIFO head, 111 when the FIFO is empty.
// R7: Status bit 0 is a read-only flag that is one when the transmit FIFO is full.
// R8: Observe bits 7:4 count lost packets and saturate at 15.
// R9: Any write to the channel register clears the lost packet counter.
// R10: Observe bits 3:0 count retransmissions and clear when a new packet starts.
// R11: The host may turn a lossy transmitter into a receiver to check for a carrier; this block only reports carrierDetect at the carrier address.
// R12: The retransmit count setting allows 0 to 15 retries before the limit flag rises.
// R13: Writing zero to a status flag, or writing read-only fields, changes nothing.
package rsor_pkg;

	// ----------------------------------------
	// Command and register addresses
	// ----------------------------------------
	localparam logic [2:0] CMD_READ = 3'h0;
	localparam logic [2:0] CMD_WRITE = 3'h1;
	localparam logic [4:0] ADDR_CHANNEL = 5'h05;
	localparam logic [4:0] ADDR_STATUS = 5'h07;
	localparam logic [4:0] ADDR_OBSERVE = 5'h08;
	localparam logic [4:0] ADDR_CARRIER = 5'h09;

	// ----------------------------------------
	// Field positions and values
	// ----------------------------------------
	localparam int BIT_RX_READY = 6;
	localparam int BIT_TX_SENT = 5;
	localparam int BIT_LIMIT = 4;
	localparam logic [3:0] LOST_MAX = 4'hf;
	localparam logic [2:0] PIPE_EMPTY = 3'h7;
	localparam logic [2:0] BIT_LAST = 3'h7;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic [2:0] PIPE_RST = 3'h7;
	localparam logic [2:0] PIN_RST = 3'h1;
	localparam logic [3:0] COUNT_RST = 4'h0;

	typedef enum logic [1:0] {PH_CMD, PH_DATA, PH_IGNORE} rsor_phase_t;

endpackage

// ---- rtl/rsor_sync.sv ----
// Two flip-flop synchroniser for asynchronous input pins
`timescale 1ns/1ns
module rsor_sync #(
	parameter int WIDTH = 3,
	parameter logic [WIDTH-1:0] RST_VAL = '0
)(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic [WIDTH-1:0] asyncIn,
	output logic [WIDTH-1:0] syncOut
);

	logic [WIDTH-1:0] stage1_q;
	logic [WIDTH-1:0] stage2_q;

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			stage1_q <= RST_VAL;
			stage2_q <= RST_VAL;
		end
		else
		begin
			stage1_q <= asyncIn;
			stage2_q <= stage1_q;
		end
	end

	assign syncOut = stage2_q;

endmodule

// ---- rtl/rsor_status_observe.sv ----
// Serial slave with status flags, FIFO status and transmit observation counters
`timescale 1ns/1ns
module rsor_status_observe
	import rsor_pkg::*;
(
	input wire logic clk,
	input wire logic rst_b,
	input wire logic spiSck,
	input wire logic spiMosi,
	input wire logic spiCs_b,
	output logic spiMiso,
	output logic spiMisoOe,
	input wire logic rxPayloadIn,
	input wire logic [2:0] rxHeadPipe,
	input wire logic rxFifoEmpty,
	input wire logic txFifoFull,
	input wire logic txStart,
	input wire logic txDone,
	input wire logic ackRcvd,
	input wire logic ackTimeout,
	input wire logic autoAckEn,
	input wire logic [3:0] arcSetting,
	input wire logic carrierDetect,
	output logic retransmitReq,
	output logic txHalt
);

	// ----------------------------------------
	// Pin synchronisation and edges
	// ----------------------------------------
	logic [2:0] pinSync;
	logic sckS;
	logic mosiS;
	logic csS_b;
	logic sckPrev_q;
	logic sckRise;
	logic sckFall;

	rsor_sync #(.WIDTH(3), .RST_VAL(PIN_RST)) u_sync (
		.clk(clk),
		.rst_b(rst_b),
		.asyncIn({spiSck, spiMosi, spiCs_b}),
		.syncOut(pinSync)
	);

	assign sckS = pinSync[2];
	assign mosiS = pinSync[1];
	assign csS_b = pinSync[0];
	assign sckRise = sckS && !sckPrev_q;
	assign sckFall = !sckS && sckPrev_q;

	// ----------------------------------------
	// Flag and counter state
	// ----------------------------------------
	logic rxReady_q, rxReady_d;
	logic sent_q, sent_d;
	logic limit_q, limit_d;
	logic [2:0] pipe_q, pipe_d;
	logic full_q, full_d;
	logic [3:0] lost_q, lost_d;
	logic [3:0] arc_q, arc_d;
	logic retx_q, retx_d;
	logic [7:0] statusByte;
	logic [7:0] observeByte;
	logic wrStb_q, wrStb_d;
	logic [4:0] wrAddr_q, wrAddr_d;
	logic [7:0] wrData_q, wrData_d;
	logic statusClr;
	logic chanWr;
	logic sentEv;
	logic limitEv;
	logic retryEv;

	assign statusByte = {1'b0, rxReady_q, sent_q, limit_q, pipe_q, full_q};
	assign observeByte = {lost_q, arc_q};
	assign statusClr = wrStb_q && wrAddr_q == ADDR_STATUS;
	assign chanWr = wrStb_q && wrAddr_q == ADDR_CHANNEL;
	assign sentEv = autoAckEn ? ackRcvd : txDone;
	assign limitEv = ackTimeout && !limit_q && arc_q == arcSetting;
	assign retryEv = ackTimeout && !limit_q && arc_q != arcSetting;

	always_comb
	begin
		// Status flags: set wins over a clear in the same cycle; the counter clears win over counting
		rxReady_d = rxPayloadIn || (rxReady_q && !(statusClr && wrData_q[BIT_RX_READY])); // [R2] [R13]
		sent_d = sentEv || (sent_q && !(statusClr && wrData_q[BIT_TX_SENT])); // [R3] [R13]
		limit_d = limitEv || (limit_q && !(statusClr && wrData_q[BIT_LIMIT])); // [R4] [R12] [R13]
		pipe_d = rxFifoEmpty ? PIPE_EMPTY : rxHeadPipe; // [R6]
		full_d = txFifoFull; // [R7]
		retx_d = retryEv; // [R5] [R12]
		arc_d = arc_q;
		if (txStart)
			arc_d = COUNT_RST; // [R10]
		else if (retryEv)
			arc_d = arc_q + 4'h1; // [R10]
		lost_d = lost_q;
		if (chanWr)
			lost_d = COUNT_RST; // [R9]
		else if (limitEv && lost_q != LOST_MAX)
			lost_d = lost_q + 4'h1; // [R8]
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			rxReady_q <= 1'b0;
			sent_q <= 1'b0;
			limit_q <= 1'b0;
			pipe_q <= PIPE_RST;
			full_q <= 1'b0;
			lost_q <= COUNT_RST;
			arc_q <= COUNT_RST;
			retx_q <= 1'b0;
		end
		else
		begin
			rxReady_q <= rxReady_d;
			sent_q <= sent_d;
			limit_q <= limit_d;
			pipe_q <= pipe_d;
			full_q <= full_d;
			lost_q <= lost_d;
			arc_q <= arc_d;
			retx_q <= retx_d;
		end
	end

	assign retransmitReq = retx_q;
	assign txHalt = limit_q; // [R5]

	// ----------------------------------------
	// Serial slave
	// ----------------------------------------
	rsor_phase_t phase_q, phase_d;
	logic [2:0] bitCnt_q, bitCnt_d;
	logic [7:0] rxShift_q, rxShift_d;
	logic [7:0] txShift_q, txShift_d;
	logic isWrite_q, isWrite_d;
	logic [4:0] addr_q, addr_d;
	logic miso_q, miso_d;
	logic misoOe_q, misoOe_d;
	logic [7:0] rxByte;

	function automatic logic [7:0] regRead(input logic [4:0] a, input logic [7:0] st,
		input logic [7:0] ob, input logic cd);
		logic [7:0] v;
		v = 8'h00;
		if (a == ADDR_STATUS)
			v = st;
		else if (a == ADDR_OBSERVE)
			v = ob;
		else if (a == ADDR_CARRIER)
			v = {7'h00, cd};
		return v;
	endfunction

	assign rxByte = {rxShift_q[6:0], mosiS};

	always_comb
	begin
		phase_d = phase_q;
		bitCnt_d = bitCnt_q;
		rxShift_d = rxShift_q;
		txShift_d = txShift_q;
		isWrite_d = isWrite_q;
		addr_d = addr_q;
		wrStb_d = 1'b0;
		wrAddr_d = wrAddr_q;
		wrData_d = wrData_q;
		miso_d = 1'b0;
		misoOe_d = 1'b0;
		if (csS_b)
		begin
			phase_d = PH_CMD;
			bitCnt_d = 3'h0;
			txShift_d = statusByte; // [R1]
		end
		else
		begin
			misoOe_d = 1'b1;
			if (sckRise)
			begin
				rxShift_d = rxByte;
				bitCnt_d = bitCnt_q + 3'h1;
				if (bitCnt_q == BIT_LAST)
				begin
					unique case (phase_q)
						PH_CMD:
						begin
							addr_d = rxByte[4:0];
							isWrite_d = rxByte[7:5] == CMD_WRITE;
							if (rxByte[7:5] == CMD_WRITE || rxByte[7:5] == CMD_READ)
								phase_d = PH_DATA;
							else
								phase_d = PH_IGNORE;
						end
						PH_DATA:
						begin
							wrStb_d = isWrite_q; // [R9] [R13]
							wrAddr_d = addr_q;
							wrData_d = rxByte;
							phase_d = PH_IGNORE;
						end
						PH_IGNORE:
							phase_d = PH_IGNORE;
					endcase
				end
			end
			else if (sckFall)
			begin
				if (bitCnt_q == 3'h0)
				begin
					if (phase_q == PH_DATA && !isWrite_q)
						txShift_d = regRead(addr_q, statusByte, observeByte, carrierDetect);
					else
						txShift_d = 8'h00;
				end
				else
					txShift_d = {txShift_q[6:0], 1'b0}; // [R1]
			end
			miso_d = txShift_d[7]; // [R1]
		end
	end

	always_ff @(posedge clk or negedge rst_b)
	begin
		if (!rst_b)
		begin
			sckPrev_q <= 1'b0;
			phase_q <= PH_CMD;
			bitCnt_q <= 3'h0;
			rxShift_q <= 8'h00;
			txShift_q <= 8'h00;
			isWrite_q <= 1'b0;
			addr_q <= 5'h00;
			wrStb_q <= 1'b0;
			wrAddr_q <= 5'h00;
			wrData_q <= 8'h00;
			miso_q <= 1'b0;
			misoOe_q <= 1'b0;
		end
		else
		begin
			sckPrev_q <= sckS;
			phase_q <= phase_d;
			bitCnt_q <= bitCnt_d;
			rxShift_q <= rxShift_d;
			txShift_q <= txShift_d;
			isWrite_q <= isWrite_d;
			addr_q <= addr_d;
			wrStb_q <= wrStb_d;
			wrAddr_q <= wrAddr_d;
			wrData_q <= wrData_d;
			miso_q <= miso_d;
			misoOe_q <= misoOe_d;
		end
	end

	assign spiMiso = miso_q;
	assign spiMisoOe = misoOe_q;

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_first_bit;
		@(posedge clk) disable iff (!rst_b)
		$rose(spiMisoOe) |-> txShift_q == $past(statusByte, 2);
	endproperty
	a_first_bit: assert property (p_first_bit) else $error("first bit is not status msb"); // [R1]

	property p_rx_set;
		@(posedge clk) disable iff (!rst_b)
		rxPayloadIn |=> rxReady_q;
	endproperty
	a_rx_set: assert property (p_rx_set) else $error("receive ready flag not set"); // [R2]

	property p_sent_aa;
		@(posedge clk) disable iff (!rst_b)
		(autoAckEn && !ackRcvd && !sent_q) |=> !sent_q;
	endproperty
	a_sent_aa: assert property (p_sent_aa) else $error("sent flag set without acknowledge"); // [R3]

	property p_limit_keep;
		@(posedge clk) disable iff (!rst_b)
		(limit_q && !(statusClr && wrData_q[BIT_LIMIT])) |=> limit_q;
	endproperty
	a_limit_keep: assert property (p_limit_keep) else $error("limit flag lost without clear"); // [R4]

	property p_halt;
		@(posedge clk) disable iff (!rst_b)
		limit_q |-> txHalt && !retransmitReq ##1 !retransmitReq;
	endproperty
	a_halt: assert property (p_halt) else $error("retransmit while limit flag set"); // [R5]

	property p_pipe;
		@(posedge clk) disable iff (!rst_b)
		rxFifoEmpty |=> pipe_q == PIPE_EMPTY;
	endproperty
	a_pipe: assert property (p_pipe) else $error("empty fifo not shown as 111"); // [R6]

	property p_full;
		@(posedge clk) disable iff (!rst_b)
		txFifoFull |=> statusByte[0];
	endproperty
	a_full: assert property (p_full) else $error("full flag missing"); // [R7]

	property p_lost_sat;
		@(posedge clk) disable iff (!rst_b)
		(lost_q == LOST_MAX && !chanWr) |=> lost_q == LOST_MAX;
	endproperty
	a_lost_sat: assert property (p_lost_sat) else $error("lost counter wrapped"); // [R8]

	property p_chan_clr;
		@(posedge clk) disable iff (!rst_b)
		chanWr |=> lost_q == 4'h0;
	endproperty
	a_chan_clr: assert property (p_chan_clr) else $error("channel write kept lost count"); // [R9]

	property p_arc_clr;
		@(posedge clk) disable iff (!rst_b)
		txStart |=> arc_q == 4'h0;
	endproperty
	a_arc_clr: assert property (p_arc_clr) else $error("retransmit count not cleared"); // [R10]

	property p_limit_set;
		@(posedge clk) disable iff (!rst_b)
		(ackTimeout && !limit_q && arc_q == arcSetting) |=> limit_q && !retransmitReq;
	endproperty
	a_limit_set: assert property (p_limit_set) else $error("limit flag not raised"); // [R12]

	property p_zero_write;
		@(posedge clk) disable iff (!rst_b)
		(statusClr && !wrData_q[BIT_RX_READY] && rxReady_q) |=> rxReady_q;
	endproperty
	a_zero_write: assert property (p_zero_write) else $error("zero write cleared flag"); // [R13]

endmodule

// ---- test/rsor_host_model.sv ----
// Serial host model that drives frames on the register link
`timescale 1ns/1ns
module rsor_host_model
(
	input wire logic clk,
	output logic sck,
	output logic mosi,
	output logic csB,
	input wire logic miso
);
	// ----------------------------------------
	// Idle pins, clock stands low between frames
	// ----------------------------------------
	initial
	begin
		sck = 1'b0;
		mosi = 1'b0;
		csB = 1'b1;
	end

	// ----------------------------------------
	// One frame: command byte, then one data byte
	// ----------------------------------------
	task automatic xfer(input logic [7:0] cmd, input logic [7:0] dat, output logic [7:0] st,
		output logic [7:0] rd);
		logic [15:0] tx;
		logic [15:0] rx;
		tx = {cmd, dat};
		rx = 16'h0000;
		@(posedge clk);
		csB <= 1'b0;
		mosi <= tx[15];
		for (int i = 15; i >= 0; i--)
		begin
			repeat (4) @(posedge clk);
			sck <= 1'b1;
			rx[i] = miso;
			repeat (4) @(posedge clk);
			sck <= 1'b0;
			if (i > 0)
				mosi <= tx[i - 1];
		end
		repeat (4) @(posedge clk);
		csB <= 1'b1;
		mosi <= ~mosi;
		repeat (8) @(posedge clk);
		st = rx[15:8];
		rd = rx[7:0];
	endtask
endmodule

// ---- test/rsor_status_observe_test.sv ----
// Self-checking bench of the status and observe registers
`timescale 1ns/1ns
module rsor_status_observe_test
	import rsor_pkg::*;
;
	logic clk, rst_b, sck, mosi, csB, miso, misoOe, rxEmpty, txFull, autoAck, cd, reReq, halt;
	logic [4:0] ev;
	logic [2:0] pipe;
	logic [3:0] arcSet;
	logic [7:0] s, v;
	int fails, tests_run, mRx, mTx, mLim, mLost, mArc, a;

	rsor_host_model host (.clk(clk), .sck(sck), .mosi(mosi), .csB(csB), .miso(miso));

	rsor_status_observe uut (.clk(clk), .rst_b(rst_b), .spiSck(sck), .spiMosi(mosi),
		.spiCs_b(csB), .spiMiso(miso), .spiMisoOe(misoOe), .rxPayloadIn(ev[0]),
		.rxHeadPipe(pipe), .rxFifoEmpty(rxEmpty), .txFifoFull(txFull), .txStart(ev[1]),
		.txDone(ev[2]), .ackRcvd(ev[3]), .ackTimeout(ev[4]), .autoAckEn(autoAck),
		.arcSetting(arcSet), .carrierDetect(cd), .retransmitReq(reReq), .txHalt(halt));

	// ----------------------------------------
	// Compare and report
	// ----------------------------------------
	task automatic check(input string n, input logic [7:0] seen, input logic [7:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("BAD %s exp %h seen %h", n, exp, seen);
		end
	endtask

	task automatic close_out();
		$display("Checks %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask

	// ----------------------------------------
	// Register access and reference model
	// ----------------------------------------
	function automatic logic [7:0] expSt();
		return {1'b0, mRx[0], mTx[0], mLim[0], rxEmpty ? 3'h7 : pipe, txFull};
	endfunction

	task automatic wr(input logic [4:0] ad, input logic [7:0] d);
		logic [7:0] x, y;
		host.xfer({3'h1, ad}, d, x, y);
		if (ad == ADDR_STATUS)
		begin
			mRx = d[6] ? 0 : mRx;
			mTx = d[5] ? 0 : mTx;
			mLim = d[4] ? 0 : mLim;
		end
		if (ad == ADDR_CHANNEL)
			mLost = 0;
	endtask

	task automatic chk();
		check("miso enable idle", {7'h00, misoOe}, 8'h00);
		host.xfer({3'h0, ADDR_STATUS}, 8'h00, s, v);
		check("status shifted with command", s, expSt());
		check("status", v, expSt());
		host.xfer({3'h0, ADDR_OBSERVE}, 8'h00, s, v);
		check("observe", v, {mLost[3:0], mArc[3:0]});
		host.xfer({3'h0, ADDR_CARRIER}, 8'h00, s, v);
		check("carrier", v, {7'h00, cd});
	endtask

	task automatic pulse(input int k);
		int rq;
		rq = 0;
		@(posedge clk) ev[k] <= 1'b1;
		@(posedge clk) ev[k] <= 1'b0;
		#1;
		case (k)
			0: mRx = 1;
			1: mArc = 0;
			2: mTx = autoAck ? mTx : 1;
			3: mTx = autoAck ? 1 : mTx;
			default:
				if (mLim == 0 && mArc < arcSet)
				begin
					mArc++;
					rq = 1;
				end
				else if (mLim == 0)
				begin
					mLim = 1;
					mLost = (mLost < 15) ? mLost + 1 : 15;
				end
		endcase
		check("retransmit request", {7'h00, reReq}, {7'h00, rq[0]});
		check("halt", {7'h00, halt}, {7'h00, mLim[0]});
	endtask

	// ----------------------------------------
	// Clock and main sequence
	// ----------------------------------------
	initial
	begin
		clk = 1'b0;
		forever #10 clk = ~clk;
	end

	initial
	begin
		{fails, tests_run, mRx, mTx, mLim, mLost, mArc} = '0;
		{rst_b, ev, pipe, txFull, autoAck, arcSet, cd} = '0;
		rxEmpty = 1'b1;
		void'($urandom(6));
		repeat (4) @(posedge clk);
		rst_b <= 1'b1;
		repeat (4) @(posedge clk);
		chk();
		pulse(2);
		pulse(0);
		chk();
		wr(ADDR_STATUS, 8'h20);
		@(posedge clk) autoAck <= 1'b1;
		pulse(2);
		chk();
		pulse(3);
		wr(ADDR_STATUS, 8'h8f);
		wr(ADDR_OBSERVE, 8'hff);
		chk();
		wr(ADDR_STATUS, 8'h70);
		chk();
		for (int r = 0; r < 3; r++)
		begin
			a = $urandom % 16;
			@(posedge clk) arcSet <= 4'(a);
			pulse(1);
			repeat (a + 2) pulse(4);
			chk();
			pulse(1);
			chk();
			wr(ADDR_STATUS, 8'h10);
		end
		@(posedge clk) arcSet <= 4'h0;
		repeat (17)
		begin
			pulse(4);
			wr(ADDR_STATUS, 8'h10);
		end
		chk();
		wr(ADDR_CHANNEL, 8'h02);
		chk();
		for (int p = 0; p < 6; p++)
		begin
			@(posedge clk);
			pipe <= 3'(p);
			rxEmpty <= 1'b0;
			txFull <= 1'($urandom % 2);
			cd <= 1'($urandom % 2);
			chk();
		end
		close_out();
	end
endmodule
